// >>> logic/tsrc_pkg.sv
// Behaviour
// - Read-only result at pointer zero, low nibble zero
// - Result weighting: whole degrees, then sixteenths
// - Settings register at pointer one, low byte ones
// - Single shot in shutdown; bit reads zero
// - Rate field selects 37/18/9/4 per second
// - Fault field needs 1/2/4/6 faults
// - Polarity bit: zero active low, one high
// - Mode bit: zero comparator, one interrupt
// - Shutdown bit stops continuous conversion
// - Lower limit at pointer two, resets 75 degrees
// - Upper limit at pointer three, resets 80 degrees
// - Limits share the result number format
// - Three pins give low bus address bits
// - Two pointer bits select the register
// - Finish conversion; shutdown edge clears alert, faults
// - Single shot ends back in shutdown
// - Convert at once after reset, then rate
package tsrc_pkg;
  localparam int CLK_HZ       = 100_000_000;
  localparam int CONV_TIME_MS = 27;
  localparam int CONV_CYC     = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int RATE1_HZ     = 18;
  localparam int RATE2_HZ     = 9;
  localparam int RATE3_HZ     = 4;
  localparam int IDLE1_CYC    = CLK_HZ / RATE1_HZ - CONV_CYC;
  localparam int IDLE2_CYC    = CLK_HZ / RATE2_HZ - CONV_CYC;
  localparam int IDLE3_CYC    = CLK_HZ / RATE3_HZ - CONV_CYC;
  localparam int CNT_W        = 25;

  // Twelve bits: eight whole degrees, four sixteenths
  localparam int RES_W    = 12;
  localparam int TEMP_LSB = 4;
  localparam int WORD_W   = 16;

  localparam int         PTR_W      = 2;
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_CFG    = 2'h1;
  localparam logic [1:0] PTR_LOW    = 2'h2;
  localparam logic [1:0] PTR_HIGH   = 2'h3;

  localparam logic [1:0] KIND_PTR   = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ  = 2'h2;
  localparam logic [1:0] KIND_ARESP = 2'h3;

  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [15:0] CFG_RESET    = 16'h00FF;
  localparam logic [15:0] LOW_RESET    = 16'h4B00;
  localparam logic [15:0] HIGH_RESET   = 16'h5000;

  localparam int CFG_SHOT     = 15;
  localparam int CFG_RATE_HI  = 14;
  localparam int CFG_RATE_LO  = 13;
  localparam int CFG_FAULT_HI = 12;
  localparam int CFG_FAULT_LO = 11;
  localparam int CFG_POLARITY = 10;
  localparam int CFG_MODE     = 9;
  localparam int CFG_PDOWN    = 8;
  localparam int CFG_RSV_HI   = 7;

  localparam logic [2:0] FAULT_LIMIT [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

  // Arbitrary upper address bits
  localparam logic [3:0] ADDR_BASE = 4'h5;

  typedef enum logic [1:0] {ST_CONV, ST_IDLE, ST_SHUT} tsrc_state_type;
endpackage

// >>> logic/tsrc_sync.sv
`timescale 1ns/1ns
module tsrc_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      q        <= '0;
    end else begin
      stage1_r <= d;
      q        <= stage1_r;
    end
  end
endmodule

// >>> logic/tsrc_alert.sv
`timescale 1ns/1ns
module tsrc_alert
  import tsrc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // New result and limits
  input  wire logic             evt,
  input  wire logic [RES_W-1:0] temp,
  input  wire logic [RES_W-1:0] lowLim,
  input  wire logic [RES_W-1:0] highLim,
  // Settings
  input  wire logic [1:0]       faultSel,
  input  wire logic             intMode,
  // Clears
  input  wire logic             clr,
  input  wire logic             ack,
  // Logical alert state
  output logic                  active
);
  logic       active_r, active_nxt;
  logic       armLow_r, armLow_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] lim;
  logic       lookLow, hit, reach;

  always_comb begin
    lim     = FAULT_LIMIT[faultSel];
    // Interrupt mode rearms for the opposite limit
    lookLow = intMode ? armLow_r : active_r;
    hit     = lookLow ? ($signed(temp) < $signed(lowLim))
                      : ($signed(temp) >= $signed(highLim));
    reach   = (cnt_r + 3'h1) >= lim;
    active_nxt = active_r;
    armLow_nxt = armLow_r;
    cnt_nxt    = cnt_r;
    if (intMode && ack) begin
      active_nxt = 1'b0;
    end
    // A qualifying event in the ack cycle is ignored while active_r is still set
    if (evt && !(intMode && active_r)) begin
      if (!hit) begin
        cnt_nxt = '0;
      end else if (reach) begin
        cnt_nxt = '0;
        if (intMode) begin
          active_nxt = 1'b1;
          armLow_nxt = ~armLow_r;
        end else begin
          active_nxt = ~active_r;
        end
      end else begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
    if (clr) begin
      active_nxt = 1'b0;
      armLow_nxt = 1'b0;
      cnt_nxt    = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      armLow_r <= 1'b0;
      cnt_r    <= '0;
    end else begin
      active_r <= active_nxt;
      armLow_r <= armLow_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign active = active_r;

  a_fault_qual: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(active_r) |-> $past(evt) && ($past(cnt_r) + 3'h1 >= $past(lim)))
    else $error("alert set without a full fault queue");

  a_cmp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !intMode && !evt && !clr |=> $stable(active_r))
    else $error("comparator alert changed without a result");

  a_int_ack: assert property (@(posedge clk) disable iff (!rst_n)
    intMode && ack && !evt |=> !active_r)
    else $error("interrupt alert not released by host access");
endmodule

// >>> logic/tsrc_core.sv
`timescale 1ns/1ns
module tsrc_core
  import tsrc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int IDLE_18HZ   = IDLE1_CYC,
  parameter int IDLE_9HZ    = IDLE2_CYC,
  parameter int IDLE_4HZ    = IDLE3_CYC
) (
  // Core clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Converter
  input  wire logic [RES_W-1:0]  adcSample,
  output logic                   convActive,
  // Address-select pins
  input  wire logic              addrSelect0,
  input  wire logic              addrSelect1,
  input  wire logic              addrSelect2,
  output logic      [6:0]        devAddr,
  // Alert pin, open drain
  output logic                   alertOut,
  output logic                   alertOe,
  // Link side
  input  wire logic              linkClk,
  input  wire logic              reqValid,
  input  wire logic [1:0]        reqKind,
  input  wire logic [WORD_W-1:0] reqData,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic      [WORD_W-1:0] rspData
);
  // Link domain state
  logic              reqT_r, reqT_nxt;
  logic [1:0]        linkKind_r, linkKind_nxt;
  logic [WORD_W-1:0] linkData_r, linkData_nxt;
  logic              ackSeen_r, ackSeen_nxt;
  logic              reqReady_r, reqReady_nxt;
  logic              rspValid_r, rspValid_nxt;
  logic [WORD_W-1:0] rspData_r, rspData_nxt;
  logic              ackSync;

  // Core register state
  logic [CFG_RATE_HI:CFG_PDOWN] cfg_r, cfg_nxt;
  logic [RES_W-1:0]  low_r, low_nxt;
  logic [RES_W-1:0]  high_r, high_nxt;
  logic [PTR_W-1:0]  ptr_r, ptr_nxt;
  logic              shotReq_r, shotReq_nxt;
  logic [WORD_W-1:0] coreRd_r, coreRd_nxt;
  logic              ackT_r, ackT_nxt;
  logic              reqSeen_r, reqSeen_nxt;
  logic              reqSync, reqEdge, intAck;
  logic [WORD_W-1:0] rdView;

  // Sequencer state
  tsrc_state_type    state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [RES_W-1:0]  result_r, result_nxt;
  logic              shotRun_r, shotRun_nxt;
  logic              lastShot_r, lastShot_nxt;
  logic              wasShut_r;
  logic [CNT_W-1:0]  idleLen;
  logic              convEnd, resEvt, shotTake, shdnClr;

  // Pin state
  logic [2:0]        addrSync;
  logic              alertAct;
  logic [6:0]        devAddr_r;
  logic              alertOe_r, alertOut_r, convActive_r;

  // Crossings: toggles for events, words held stable by the handshake
  tsrc_sync #(.W(1)) u_reqSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (reqT_r),
    .q     (reqSync)
  );

  tsrc_sync #(.W(1)) u_ackSync (
    .clk   (linkClk),
    .rst_n (rst_n),
    .d     (ackT_r),
    .q     (ackSync)
  );

  tsrc_sync #(.W(3)) u_addrSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({addrSelect2, addrSelect1, addrSelect0}),
    .q     (addrSync)
  );

  // Link side: one request in flight, answered once the core acks
  always_comb begin
    reqT_nxt     = reqT_r;
    linkKind_nxt = linkKind_r;
    linkData_nxt = linkData_r;
    ackSeen_nxt  = ackSeen_r;
    reqReady_nxt = reqReady_r;
    rspValid_nxt = 1'b0;
    rspData_nxt  = rspData_r;
    if (reqValid && reqReady_r) begin
      reqT_nxt     = ~reqT_r;
      linkKind_nxt = reqKind;
      linkData_nxt = reqData;
      reqReady_nxt = 1'b0;
    end
    if (ackSync != ackSeen_r) begin
      ackSeen_nxt  = ackSync;
      rspValid_nxt = 1'b1;
      rspData_nxt  = coreRd_r;
      reqReady_nxt = 1'b1;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      reqT_r     <= 1'b0;
      linkKind_r <= KIND_PTR;
      linkData_r <= '0;
      ackSeen_r  <= 1'b0;
      reqReady_r <= 1'b1;
      rspValid_r <= 1'b0;
      rspData_r  <= '0;
    end else begin
      reqT_r     <= reqT_nxt;
      linkKind_r <= linkKind_nxt;
      linkData_r <= linkData_nxt;
      ackSeen_r  <= ackSeen_nxt;
      reqReady_r <= reqReady_nxt;
      rspValid_r <= rspValid_nxt;
      rspData_r  <= rspData_nxt;
    end
  end

  // Register file
  always_comb begin
    reqEdge = reqSync != reqSeen_r;
    case (ptr_r)
      PTR_RESULT: rdView = {result_r, {TEMP_LSB{1'b0}}};
      PTR_CFG:    rdView = {1'b0, cfg_r, CFG_RESET[CFG_RSV_HI:0]};
      PTR_LOW:    rdView = {low_r, {TEMP_LSB{1'b0}}};
      PTR_HIGH:   rdView = {high_r, {TEMP_LSB{1'b0}}};
      default:    rdView = '0;
    endcase
    cfg_nxt     = cfg_r;
    low_nxt     = low_r;
    high_nxt    = high_r;
    ptr_nxt     = ptr_r;
    shotReq_nxt = shotReq_r & ~shotTake;
    coreRd_nxt  = coreRd_r;
    ackT_nxt    = ackT_r;
    reqSeen_nxt = reqSync;
    intAck      = 1'b0;
    if (reqEdge) begin
      ackT_nxt   = ~ackT_r;
      coreRd_nxt = rdView;
      case (linkKind_r)
        KIND_PTR: ptr_nxt = linkData_r[PTR_W-1:0];
        KIND_WRITE: begin
          case (ptr_r)
            PTR_CFG: begin
              cfg_nxt = linkData_r[CFG_RATE_HI:CFG_PDOWN];
              // Set wins over the sequencer's take
              if (linkData_r[CFG_SHOT] && linkData_r[CFG_PDOWN]) begin
                shotReq_nxt = 1'b1;
              end
            end
            PTR_LOW:  low_nxt  = linkData_r[WORD_W-1:TEMP_LSB];
            PTR_HIGH: high_nxt = linkData_r[WORD_W-1:TEMP_LSB];
            default: ;
          endcase
        end
        KIND_READ:  intAck = 1'b1;
        KIND_ARESP: intAck = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r     <= CFG_RESET[CFG_RATE_HI:CFG_PDOWN];
      low_r     <= LOW_RESET[WORD_W-1:TEMP_LSB];
      high_r    <= HIGH_RESET[WORD_W-1:TEMP_LSB];
      ptr_r     <= PTR_RESULT;
      shotReq_r <= 1'b0;
      coreRd_r  <= '0;
      ackT_r    <= 1'b0;
      reqSeen_r <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      low_r     <= low_nxt;
      high_r    <= high_nxt;
      ptr_r     <= ptr_nxt;
      shotReq_r <= shotReq_nxt;
      coreRd_r  <= coreRd_nxt;
      ackT_r    <= ackT_nxt;
      reqSeen_r <= reqSeen_nxt;
    end
  end

  // Conversion sequencer
  always_comb begin
    case (cfg_r[CFG_RATE_HI:CFG_RATE_LO])
      2'h1:    idleLen = CNT_W'(IDLE_18HZ);
      2'h2:    idleLen = CNT_W'(IDLE_9HZ);
      2'h3:    idleLen = CNT_W'(IDLE_4HZ);
      default: idleLen = '0;
    endcase
    convEnd    = cnt_r == CNT_W'(CONV_CYCLES - 1);
    state_nxt  = state_r;
    cnt_nxt    = cnt_r + 1'b1;
    result_nxt = result_r;
    shotRun_nxt  = shotRun_r;
    lastShot_nxt = lastShot_r;
    resEvt       = 1'b0;
    shotTake     = 1'b0;
    case (state_r)
      ST_CONV: begin
        // Shutdown only takes effect once this conversion is done
        if (convEnd) begin
          result_nxt   = adcSample;
          resEvt       = 1'b1;
          cnt_nxt      = '0;
          shotRun_nxt  = 1'b0;
          lastShot_nxt = shotRun_r;
          if (cfg_r[CFG_PDOWN] || shotRun_r) begin
            state_nxt = ST_SHUT;
          end else if (idleLen != '0) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (cfg_r[CFG_PDOWN]) begin
          state_nxt    = ST_SHUT;
          lastShot_nxt = 1'b0;
          cnt_nxt    = '0;
        end else if (cnt_r >= idleLen - 1'b1) begin
          state_nxt = ST_CONV;
          cnt_nxt   = '0;
        end
      end
      ST_SHUT: begin
        cnt_nxt = '0;
        if (shotReq_r) begin
          state_nxt   = ST_CONV;
          shotRun_nxt = 1'b1;
          shotTake    = 1'b1;
        end else if (!cfg_r[CFG_PDOWN]) begin
          state_nxt = ST_CONV;
          shotTake  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_CONV;
        cnt_nxt   = '0;
      end
    endcase
    // Return from a single shot is not a new shutdown edge
    shdnClr = (state_r == ST_SHUT) && !wasShut_r && !lastShot_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_CONV;
      cnt_r     <= '0;
      result_r  <= RESULT_RESET;
      shotRun_r  <= 1'b0;
      lastShot_r <= 1'b0;
      wasShut_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      result_r  <= result_nxt;
      shotRun_r  <= shotRun_nxt;
      lastShot_r <= lastShot_nxt;
      wasShut_r <= state_r == ST_SHUT;
    end
  end

  tsrc_alert u_alert (
    .clk      (clk),
    .rst_n    (rst_n),
    .evt      (resEvt),
    .temp     (result_nxt),
    .lowLim   (low_r),
    .highLim  (high_r),
    .faultSel (cfg_r[CFG_FAULT_HI:CFG_FAULT_LO]),
    .intMode  (cfg_r[CFG_MODE]),
    .clr      (shdnClr),
    .ack      (intAck),
    .active   (alertAct)
  );

  // Pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      devAddr_r    <= '0;
      alertOe_r    <= 1'b0;
      alertOut_r   <= 1'b0;
      convActive_r <= 1'b1;
    end else begin
      devAddr_r    <= {ADDR_BASE, addrSync};
      // Open drain: pull low when the pin level is to be low
      alertOe_r    <= alertAct ^ cfg_r[CFG_POLARITY];
      alertOut_r   <= 1'b0;
      convActive_r <= state_nxt == ST_CONV;
    end
  end

  assign devAddr    = devAddr_r;
  assign alertOe    = alertOe_r;
  assign alertOut   = alertOut_r;
  assign convActive = convActive_r;
  assign reqReady   = reqReady_r;
  assign rspValid   = rspValid_r;
  assign rspData    = rspData_r;

  a_result_view: assert property (@(posedge clk) disable iff (!rst_n)
    reqEdge && ptr_r == PTR_RESULT
    |=> coreRd_r == {$past(result_r), {TEMP_LSB{1'b0}}})
    else $error("result view wrong");

  a_cfg_view: assert property (@(posedge clk) disable iff (!rst_n)
    reqEdge && ptr_r == PTR_CFG
    |=> !coreRd_r[CFG_SHOT]
    && coreRd_r[CFG_RSV_HI:0] == CFG_RESET[CFG_RSV_HI:0])
    else $error("settings view wrong");

  a_shot_start: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_SHUT && shotReq_r |=> state_r == ST_CONV && shotRun_r)
    else $error("single shot not started");

  a_shot_return: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_CONV && shotRun_r && convEnd |=> state_r == ST_SHUT)
    else $error("single shot did not return to shutdown");

  a_sd_finish: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_CONV && !convEnd |=> state_r == ST_CONV)
    else $error("conversion cut short");

  a_shdn_clear: assert property (@(posedge clk) disable iff (!rst_n)
    shdnClr |=> !alertAct ##1 alertOe_r == cfg_r[CFG_POLARITY])
    else $error("shutdown edge did not clear alert");

  a_rate_idle: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_CONV && convEnd && !cfg_r[CFG_PDOWN] && !shotRun_r
    && idleLen != '0 |=> state_r == ST_IDLE && cnt_r == '0)
    else $error("no idle delay after conversion");

  a_continuous: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_CONV && convEnd && !cfg_r[CFG_PDOWN] && !shotRun_r
    && idleLen == '0 |=> state_r == ST_CONV && cnt_r == '0)
    else $error("continuous conversion stopped");

  a_alert_pol: assert property (@(posedge clk) disable iff (!rst_n)
    alertAct && !cfg_r[CFG_POLARITY]
    ##1 cfg_r[CFG_POLARITY] == $past(cfg_r[CFG_POLARITY])
    |-> alertOe_r && !alertOut)
    else $error("alert level wrong for polarity");

  a_addr_pins: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 devAddr_r[2:0] == $past(addrSync))
    else $error("address bits not from pins");

  a_ptr_load: assert property (@(posedge clk) disable iff (!rst_n)
    reqEdge && linkKind_r == KIND_PTR
    |=> ptr_r == $past(linkData_r[PTR_W-1:0]))
    else $error("pointer not loaded");

  a_low_write: assert property (@(posedge clk) disable iff (!rst_n)
    reqEdge && linkKind_r == KIND_WRITE && ptr_r == PTR_LOW
    |=> low_r == $past(linkData_r[WORD_W-1:TEMP_LSB]))
    else $error("lower limit write lost");
endmodule

// >>> verif/tsrc_host.sv
`timescale 1ns/1ns
module tsrc_host
  import tsrc_pkg::*;
(
  // Link clock
  input  wire logic              linkClk,
  // Request
  output logic                   reqValid,
  output logic      [1:0]        reqKind,
  output logic      [WORD_W-1:0] reqData,
  input  wire logic              reqReady,
  // Answer
  input  wire logic              rspValid,
  input  wire logic [WORD_W-1:0] rspData
);
  logic hung;

  initial begin
    reqValid = 1'b0;
    reqKind  = 2'h0;
    reqData  = 16'h0000;
    hung     = 1'b0;
  end

  // Released lines show the inverse so stale values never pass
  task automatic xfer(input logic [1:0] kind, input logic [15:0] data,
                      output logic [15:0] rsp);
    int n;
    n = 0;
    @(posedge linkClk);
    #1;
    reqValid = 1'b1;
    reqKind  = kind;
    reqData  = data;
    do begin
      @(posedge linkClk);
      n++;
    end while (reqReady !== 1'b1 && n < 40);
    #1;
    reqValid = 1'b0;
    reqKind  = ~kind;
    reqData  = ~data;
    do begin
      @(posedge linkClk);
      n++;
    end while (rspValid !== 1'b1 && n < 40);
    rsp = rspData;
    if (n >= 40)
      hung = 1'b1;
  endtask
endmodule

// >>> verif/temp_sensor_register_core_tb.sv
`timescale 1ns/1ns
module temp_sensor_register_core_tb
  import tsrc_pkg::*;
;
  localparam int CONV = 20;
  localparam int IDLE_T [4] = '{0, 10, 30, 50};

  logic              clk;
  logic              rst_n;
  logic              linkClk;
  logic [RES_W-1:0]  adcSample;
  logic [2:0]        addrSel;
  logic              convActive;
  logic [6:0]        devAddr;
  logic              alertOut;
  logic              alertOe;
  logic              reqValid;
  logic [1:0]        reqKind;
  logic [WORD_W-1:0] reqData;
  logic              reqReady;
  logic              rspValid;
  logic [WORD_W-1:0] rspData;
  logic [15:0]       v;
  logic              ok;
  int                errors;
  int                check_count;
  int                n;
  // Alert line has a pull-up
  wire alertPin = alertOe ? alertOut : 1'b1;

  tsrc_core #(
    .CONV_CYCLES(CONV), .IDLE_18HZ(IDLE_T[1]),
    .IDLE_9HZ(IDLE_T[2]), .IDLE_4HZ(IDLE_T[3])
  ) dut (
    .clk(clk), .rst_n(rst_n), .adcSample(adcSample),
    .convActive(convActive), .addrSelect0(addrSel[0]),
    .addrSelect1(addrSel[1]), .addrSelect2(addrSel[2]),
    .devAddr(devAddr), .alertOut(alertOut), .alertOe(alertOe),
    .linkClk(linkClk), .reqValid(reqValid), .reqKind(reqKind),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData)
  );

  tsrc_host host (
    .linkClk(linkClk), .reqValid(reqValid), .reqKind(reqKind),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Even offset keeps link edges off the odd-time core rising edges
  initial begin
    linkClk = 1'b1;
    #2;
    forever #6 linkClk = ~linkClk;
  end

  task automatic end_sim();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xf(input logic [1:0] k, input logic [15:0] d);
    host.xfer(k, d, v);
    if (host.hung !== 1'b0) begin
      errors++;
      $display("BAD link expected answer seen none");
      end_sim();
    end
  endtask

  task automatic wr(input logic [15:0] p, input logic [15:0] d);
    xf(KIND_PTR, p);
    xf(KIND_WRITE, d);
  endtask

  task automatic rdc(input string nm, input logic [15:0] p,
                     input logic [15:0] e);
    xf(KIND_PTR, p);
    xf(KIND_READ, 16'h0000);
    chk(nm, v, e);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Cycles until convActive or the alert line reaches lvl
  task automatic waitFor(input bit conv, input logic lvl, input int lim);
    n = 0;
    check_count++;
    while ((conv ? convActive : alertPin) !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("BAD wait expected %b seen timeout", lvl);
      end_sim();
    end
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    adcSample = 12'h123;
    addrSel = 3'h0;
    cyc(10);
    rst_n = 1'b1;
    chk("conv start", 16'(convActive), 16'h0001);
    xf(KIND_READ, 16'h0000);
    chk("result rst", v, 16'h0000);
    rdc("cfg rst", 16'h0001, CFG_RESET);
    rdc("low rst", 16'h0002, LOW_RESET);
    rdc("high rst", 16'h0003, HIGH_RESET);
    rdc("result", 16'h0000, 16'h1230);
    for (int i = 0; i < 8; i++) begin
      addrSel = 3'(i);
      cyc(4);
      chk("addr", 16'(devAddr), 16'({ADDR_BASE, 3'(i)}));
    end
    wr(16'h0002, 16'hFFFF);
    rdc("low mask", 16'h0002, 16'hFFF0);
    wr(16'h0003, 16'h000F);
    rdc("high mask", 16'h0003, 16'h0000);
    wr(16'h0003, HIGH_RESET);
    wr(16'h0002, LOW_RESET);
    wr(16'h0000, 16'hFFFF);
    rdc("result ro", 16'h0000, 16'h1230);
    wr(16'h0001, 16'h0000);
    rdc("ptr high bits", 16'h00FD, CFG_RESET);
    // Negative value must not trip an unsigned compare
    adcSample = 12'hABC;
    cyc(60);
    chk("neg pin", 16'(alertPin), 16'h0001);
    rdc("neg result", 16'h0000, 16'hABC0);
    for (int q = 0; q < 4; q++) begin
      wr(16'h0001, 16'(q) << 11);
      adcSample = 12'h500;
      waitFor(1'b0, 1'b0, 200);
      ok = n > (FAULT_LIMIT[q] - 1) * CONV && n <= FAULT_LIMIT[q] * CONV + 16;
      chk("fault set", 16'(ok), 16'h0001);
      adcSample = 12'h4AF;
      waitFor(1'b0, 1'b1, 200);
      ok = n > (FAULT_LIMIT[q] - 1) * CONV;
      chk("fault release", 16'(ok), 16'h0001);
    end
    wr(16'h0001, 16'h0400);
    cyc(5);
    chk("polarity idle", 16'(alertPin), 16'h0000);
    adcSample = 12'h500;
    waitFor(1'b0, 1'b1, 60);
    adcSample = 12'h4AF;
    waitFor(1'b0, 1'b0, 60);
    wr(16'h0001, 16'h0200);
    cyc(5);
    chk("int idle", 16'(alertPin), 16'h0001);
    adcSample = 12'h500;
    waitFor(1'b0, 1'b0, 60);
    xf(KIND_READ, 16'h0000);
    cyc(80);
    chk("int read", 16'(alertPin), 16'h0001);
    adcSample = 12'h4AF;
    waitFor(1'b0, 1'b0, 60);
    cyc(60);
    chk("int hold", 16'(alertPin), 16'h0000);
    xf(KIND_ARESP, 16'h0000);
    cyc(60);
    chk("int aresp", 16'(alertPin), 16'h0001);
    adcSample = 12'h500;
    wr(16'h0001, 16'h0000);
    waitFor(1'b0, 1'b0, 60);
    wr(16'h0001, 16'h0100);
    waitFor(1'b1, 1'b0, 40);
    cyc(5);
    chk("pdown clear", 16'(alertPin), 16'h0001);
    cyc(100);
    chk("pdown idle", 16'(convActive), 16'h0000);
    adcSample = 12'h7FF;
    wr(16'h0001, 16'h8100);
    waitFor(1'b1, 1'b1, 20);
    waitFor(1'b1, 1'b0, 40);
    cyc(100);
    chk("shot end", 16'(convActive), 16'h0000);
    rdc("shot result", 16'h0000, 16'h7FF0);
    rdc("shot bit", 16'h0001, 16'h01FF);
    for (int r = 3; r > 0; r--) begin
      wr(16'h0001, 16'(r) << 13);
      waitFor(1'b1, 1'b1, 100);
      waitFor(1'b1, 1'b0, 40);
      waitFor(1'b1, 1'b1, 100);
      ok = n >= IDLE_T[r] - 3 && n <= IDLE_T[r] + 3;
      chk("idle", 16'(ok), 16'h0001);
    end
    wr(16'h0001, 16'h0000);
    n = 0;
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      n += int'(convActive !== 1'b1);
    end
    chk("rate0", 16'(n <= 14), 16'h0001);
    end_sim();
  end
endmodule
